/* File: dsadc_consts.vh */
// constants for the dual slope converter control block
`ifndef DSADC_CONSTS_VH
`define DSADC_CONSTS_VH

// ***************************************************
// clock and timing
// ***************************************************
`define CLK_MHZ 100
`define TICK_DIV_RST 100
`define AZI_TIME_MS 100
`define IZ_TIME_US 500

// ***************************************************
// phase select codes, high bit then low bit
// ***************************************************
`define PH_AZ 2'h1
`define PH_INT 2'h2
`define PH_DEINT 2'h3
`define PH_IZ 2'h0

// ***************************************************
// result word layout
// ***************************************************
`define RES_W 18
`define RES_POL_BIT 17
`define RES_OVR_BIT 16
`define RES_CNT_W 16

// ***************************************************
// configuration word layout and reset values
// ***************************************************
`define CFG_W 16
`define CFG_INT_LSB 4
`define CFG_INT_W 12
`define CFG_RES_LSB 0
`define CFG_RES_W 4
`define CFG_INT_RST 12'h3E8
`define CFG_RES_RST 4'h0

`endif

/* File: dual_slope_adc_serial_adapter.v */
// converter phase sequencer with result shift register and serial port
//
// Functional notes
// - a low level on CONV_TRIG_N starts a conversion.
// - each result is loaded with overrange and polarity bits into an 18 bit shift register.
// - the shift register holds until the host shifts it out or the next result overwrites it.
// - RESULT_READY_N goes low at the end of each cycle to mark a fresh result.
// - results carry magnitude bits plus a separate sign bit.
// - the host programs conversion rate and resolution through the serial port.
// - the block drives the phase selects and watches the comparator on its own.
// - result and configuration traffic uses the serial wires clock, data in and data out, framed by READ_N or LOAD_N; trigger and ready have their own pins.
// - after reset the converter is held in auto zero for 100 ms before conversions.
// - phase select codes are 01 auto zero, 10 integrate, 11 de-integrate, 00 integrator zero.
// - a falling edge on the comparator input ends de-integrate.
`timescale 1ns/1ps
`default_nettype none
`include "dsadc_consts.vh"

module dual_slope_adc_serial_adapter
#(
  parameter TICK_DIV = `TICK_DIV_RST,
  parameter PWRUP_CYCLES = `AZI_TIME_MS * `CLK_MHZ * 1000,
  parameter IZ_CYCLES = `IZ_TIME_US * `CLK_MHZ
)
(
  input wire CLK_SYS,
  input wire RESET,
  input wire CONV_TRIG_N,
  input wire ZERO_CROSS_IN,
  input wire SER_CLK,
  input wire SER_DIN,
  input wire READ_N,
  input wire LOAD_N,
  output wire SER_DOUT,
  output wire PHASE_A,
  output wire PHASE_B,
  output wire RESULT_READY_N
);

  localparam ST_PWRUP = 3'h0;
  localparam ST_AZ = 3'h1;
  localparam ST_INT = 3'h2;
  localparam ST_DEINT = 3'h3;
  localparam ST_IZ = 3'h4;
  localparam NSYNC = 6;

  // ***************************************************
  // pin synchronisers: three flops, accept when 2nd and 3rd agree
  // ***************************************************
  wire [NSYNC-1:0] pin_raw;
  wire [NSYNC-1:0] pin_r;
  wire [NSYNC-1:0] pin_d_r;
  assign pin_raw = {LOAD_N, READ_N, SER_DIN, SER_CLK, ZERO_CROSS_IN, CONV_TRIG_N};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg flt_r;
      reg flt_d_r;
      // chain plus agreement filter, one process per pin
      always @(posedge CLK_SYS)
      begin
        if (RESET)
        begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          flt_r <= 1'b1;
          flt_d_r <= 1'b1;
        end
        else
        begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            flt_r <= s3_r;
          flt_d_r <= flt_r;
        end
      end
      // filtered level and its one-cycle delayed copy
      assign pin_r[gi] = flt_r;
      assign pin_d_r[gi] = flt_d_r;
    end
  endgenerate

  wire trig_low = ~pin_r[0];
  wire zc_lvl = pin_r[1];
  wire zc_fall = pin_d_r[1] & ~pin_r[1];
  wire sck_rise = ~pin_d_r[2] & pin_r[2];
  wire sck_fall = pin_d_r[2] & ~pin_r[2];
  wire din_lvl = pin_r[3];
  wire rd_act = ~pin_r[4];
  wire rd_start = pin_d_r[4] & ~pin_r[4];
  wire ld_act = ~pin_r[5];
  wire ld_end = ~pin_d_r[5] & pin_r[5];

  // ***************************************************
  // timebase tick divider
  // ***************************************************
  reg [15:0] div_r;
  wire tick = (div_r == 16'h0000);
  // one-cycle tick every TICK_DIV system clocks
  always @(posedge CLK_SYS)
  begin
    if (RESET || tick)
      div_r <= TICK_DIV[15:0] - 16'h0001;
    else
      div_r <= div_r - 16'h0001;
  end

  // ***************************************************
  // configuration shift-in: rate and resolution
  // ***************************************************
  reg [`CFG_W-1:0] cfg_sh_r;
  reg [`CFG_INT_W-1:0] int_ticks_r;
  reg [`CFG_RES_W-1:0] res_r;
  // bits shift in msb first on rising clock while load is low
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      cfg_sh_r <= {`CFG_W{1'b0}};
      int_ticks_r <= `CFG_INT_RST;
      res_r <= `CFG_RES_RST;
    end
    else
    begin
      if (ld_act && sck_rise)
        cfg_sh_r <= {cfg_sh_r[`CFG_W-2:0], din_lvl};
      if (ld_end)
      begin
        int_ticks_r <= cfg_sh_r[`CFG_INT_LSB +: `CFG_INT_W];
        res_r <= cfg_sh_r[`CFG_RES_LSB +: `CFG_RES_W];
      end
    end
  end

  // full scale count from resolution; zero selects the widest count
  wire [`RES_CNT_W:0] full_scale = (res_r == 4'h0) ? 17'h10000 :
                                   ({{`RES_CNT_W{1'b0}}, 1'b1} << res_r);

  // ***************************************************
  // phase sequencer
  // ***************************************************
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [23:0] tmr_r;
  reg [`RES_CNT_W:0] cnt_r;
  reg pol_r;
  reg ovr_r; // de-integrate ended on full scale
  reg [1:0] phase_r;
  reg [1:0] phase_nxt;
  reg load_res;

  wire pwrup_done = (tmr_r == PWRUP_CYCLES[23:0] - 24'h000001);
  wire iz_done = (tmr_r == IZ_CYCLES[23:0] - 24'h000001);
  wire int_done = tick && (cnt_r[`CFG_INT_W-1:0] == int_ticks_r);
  wire deint_ovr = (cnt_r == full_scale);

  // next state and phase code
  always @*
  begin
    st_nxt = st_r;
    load_res = 1'b0;
    case (st_r)
      ST_PWRUP:
        if (pwrup_done)
          st_nxt = ST_AZ;
      ST_AZ:
        if (trig_low)
          st_nxt = ST_INT;
      ST_INT:
        if (int_done)
          st_nxt = ST_DEINT;
      ST_DEINT:
        if (zc_fall || deint_ovr)
          st_nxt = ST_IZ;
      ST_IZ:
        if (iz_done)
        begin
          st_nxt = ST_AZ;
          load_res = 1'b1;
        end
      default:
        st_nxt = ST_PWRUP;
    endcase
    case (st_nxt)
      ST_PWRUP: phase_nxt = `PH_AZ;
      ST_AZ: phase_nxt = `PH_AZ;
      ST_INT: phase_nxt = `PH_INT;
      ST_DEINT: phase_nxt = `PH_DEINT;
      ST_IZ: phase_nxt = `PH_IZ;
      default: phase_nxt = `PH_AZ;
    endcase
  end

  // state, timers and de-integrate counter
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      st_r <= ST_PWRUP;
      phase_r <= `PH_AZ;
      tmr_r <= 24'h000000;
      cnt_r <= {(`RES_CNT_W+1){1'b0}};
      pol_r <= 1'b0;
      ovr_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      phase_r <= phase_nxt;
      if (st_nxt != st_r)
        tmr_r <= 24'h000000;
      else
        tmr_r <= tmr_r + 24'h000001;
      // count survives into integrator zero so the load there sees it
      if (st_nxt != st_r && st_nxt != ST_IZ)
        cnt_r <= {(`RES_CNT_W+1){1'b0}};
      else if (tick && (st_r == ST_INT || (st_r == ST_DEINT && !deint_ovr)))
        cnt_r <= cnt_r + {{`RES_CNT_W{1'b0}}, 1'b1};
      if (st_r == ST_DEINT && st_nxt == ST_IZ)
        ovr_r <= deint_ovr;
      if (st_r == ST_INT && st_nxt == ST_DEINT)
        pol_r <= zc_lvl; // comparator level gives input sign
    end
  end

  // ***************************************************
  // result shift register and ready flag
  // ***************************************************
  reg [`RES_W-1:0] res_sh_r;
  reg ready_n_r;
  // new result wins over a shift in the same cycle
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      res_sh_r <= {`RES_W{1'b0}};
      ready_n_r <= 1'b1;
    end
    else
    begin
      if (load_res)
        res_sh_r <= {pol_r, ovr_r, cnt_r[`RES_CNT_W-1:0]};
      else if (rd_act && sck_fall)
        res_sh_r <= {res_sh_r[`RES_W-2:0], 1'b0};
      if (load_res)
        ready_n_r <= 1'b0;
      else if (rd_start || (st_r == ST_AZ && st_nxt == ST_INT))
        ready_n_r <= 1'b1;
    end
  end

  assign SER_DOUT = res_sh_r[`RES_W-1];
  assign PHASE_A = phase_r[1];
  assign PHASE_B = phase_r[0];
  assign RESULT_READY_N = ready_n_r;

endmodule
`default_nettype wire

/* File: dsadc_chk_asserts.sv */
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module dsadc_chk #(parameter PWRUP_CYCLES = 200)
(
  input wire CLK_SYS,
  input wire RESET,
  input wire CONV_TRIG_N,
  input wire READ_N,
  input wire SER_DOUT,
  input wire PHASE_A,
  input wire PHASE_B,
  input wire RESULT_READY_N
);
  wire [1:0] ph = {PHASE_A, PHASE_B};
  reg [31:0] up_r;
  reg [3:0] rd_r;
  reg [3:0] tg_r;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // cycles since reset, and cycles the read and trigger pins stayed high
  always @(posedge CLK_SYS)
  begin
    up_r <= RESET ? 32'h0 : up_r + {31'h0, !up_r[31]};
    rd_r <= (RESET || !READ_N) ? 4'h0 : rd_r + {3'h0, rd_r != 4'hF};
    tg_r <= (RESET || !CONV_TRIG_N) ? 4'h0 : tg_r + {3'h0, tg_r != 4'hF};
  end
  chk_reset_state: assert property (disable iff (1'b0) RESET |=> ph == 2'h1 && RESULT_READY_N)
    else $error("outputs not at reset values");
  chk_phase_step: assert property ($changed(ph) |-> ph == $past(ph) + 2'h1)
    else $error("illegal phase step");
  chk_ready_load: assert property ($fell(RESULT_READY_N) |-> ph == 2'h1 && $past(ph) == 2'h0)
    else $error("ready flag fell outside a load");
  chk_load_ready: assert property (ph == 2'h1 && $past(ph) == 2'h0 |-> !RESULT_READY_N)
    else $error("load without ready flag");
  chk_ready_hold: assert property ($rose(RESULT_READY_N) |-> ph == 2'h2 || rd_r < 4'h8)
    else $error("ready flag cleared without read");
  chk_dout_hold: assert property ($changed(SER_DOUT) && rd_r > 4'h9 |-> $past(ph) == 2'h0)
    else $error("result changed while idle");
  chk_trig_start: assert property (ph == 2'h2 && $past(ph) == 2'h1 |-> tg_r < 4'h8)
    else $error("integrate without trigger");
  chk_pwrup_hold: assert property (up_r < PWRUP_CYCLES - 2 |-> ph == 2'h1)
    else $error("left auto zero during power-up");
endmodule
bind dual_slope_adc_serial_adapter dsadc_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk_i
(
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CONV_TRIG_N(CONV_TRIG_N), .READ_N(READ_N),
  .SER_DOUT(SER_DOUT), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B), .RESULT_READY_N(RESULT_READY_N)
);
`default_nettype wire

/* File: dsadc_conv_model.sv */
// comparator model of the external converter
`timescale 1ns/1ps
`default_nettype none
module dsadc_conv_model
(
  input wire logic clk,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic [15:0] deint_clks,
  output var logic zero_cross = 1'b1
);
  logic [15:0] cnt_r = 16'h0;
  // comparator falls deint_clks cycles into de-integrate
  always @(posedge clk)
  begin
    cnt_r <= ({phase_a, phase_b} == 2'h3) ? cnt_r + 16'h1 : 16'h0;
    zero_cross <= !({phase_a, phase_b} == 2'h3 && cnt_r >= deint_clks);
  end
endmodule
`default_nettype wire

/* File: dual_slope_adc_serial_adapter_tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module dual_slope_adc_serial_adapter_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trig_n = 1'b1;
  logic sclk = 1'b1;
  logic sdin = 1'b0;
  logic read_n = 1'b1;
  logic load_n = 1'b1;
  logic [15:0] dl = 16'h0190;
  logic [17:0] r;
  wire zc, dout, pa, pb, rdy_n;
  int bad_count = 0;
  int n_tests = 0;
  // free running clock
  always #5 clk = ~clk;
  dual_slope_adc_serial_adapter #(.TICK_DIV(4), .PWRUP_CYCLES(200), .IZ_CYCLES(50)) dut
  (
    .CLK_SYS(clk), .RESET(rst), .CONV_TRIG_N(trig_n), .ZERO_CROSS_IN(zc), .SER_CLK(sclk),
    .SER_DIN(sdin), .READ_N(read_n), .LOAD_N(load_n), .SER_DOUT(dout), .PHASE_A(pa),
    .PHASE_B(pb), .RESULT_READY_N(rdy_n)
  );
  dsadc_conv_model conv (.clk(clk), .phase_a(pa), .phase_b(pb), .deint_clks(dl), .zero_cross(zc));
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [17:0] lo, hi, g);
    n_tests++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h to %h seen %h", s, lo, hi, g);
    end
  endtask
  task automatic to_ph(input logic [1:0] p, input int lim);
    for (int i = 0; i < lim && {pa, pb} !== p; i++)
      tk(1);
    chk("phase", {16'h0, p}, {16'h0, p}, {16'h0, pa, pb});
  endtask
  // host shifts config in on rising or result out on falling clock
  task automatic xfer(input logic ld, input logic [15:0] cfg, output logic [17:0] rd);
    load_n <= !ld;
    read_n <= ld;
    tk(12);
    for (int i = 0; i < (ld ? 16 : 18); i++)
    begin
      rd = {rd[16:0], dout};
      sdin <= cfg[15];
      cfg = cfg << 1;
      sclk <= 1'b0;
      tk(8);
      sclk <= 1'b1;
      tk(8);
    end
    load_n <= 1'b1;
    read_n <= 1'b1;
    tk(12);
  endtask
  task automatic t_start();
    tk(8);
    chk("reset outputs", 18'h5, 18'h5, {14'h0, dout, rdy_n, pa, pb});
    rst <= 1'b0;
    trig_n <= 1'b0;
    tk(150);
    chk("power-up phase", 18'h1, 18'h1, {16'h0, pa, pb});
    to_ph(2'h2, 100);
  endtask
  task automatic t_conv();
    trig_n <= 1'b1;
    to_ph(2'h3, 5000);
    to_ph(2'h0, 600);
    to_ph(2'h1, 100);
    tk(1);
    chk("ready flag", 18'h0, 18'h0, {17'h0, rdy_n});
    xfer(1'b0, 16'h0, r);
    chk("ready cleared", 18'h1, 18'h1, {17'h0, rdy_n});
    chk("sign and count", 18'h20062, 18'h20068, r);
  endtask
  task automatic t_ovr();
    trig_n <= 1'b1;
    to_ph(2'h1, 6000);
    tk(300);
    chk("idle phase", 18'h1, 18'h1, {16'h0, pa, pb});
    xfer(1'b1, 16'h0103, r);
    dl <= 16'h07D0;
    trig_n <= 1'b0;
    to_ph(2'h2, 50);
    trig_n <= 1'b1;
    to_ph(2'h1, 400);
    xfer(1'b0, 16'h0, r);
    chk("overrange result", 18'h30008, 18'h30008, r);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence and watchdog
  initial
  begin
    t_start();
    t_conv();
    t_ovr();
    summarize();
  end
  initial
  begin
    tk(30000);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
